// *** rwpc_map.svh ***
// Register map, field positions, reset values and timing for the reset, wake and power block
`ifndef RWPC_MAP_SVH
`define RWPC_MAP_SVH

`define RWPC_CLK_MHZ 20
`define RWPC_GLITCH_NS 200
`define RWPC_GLITCH_CYC ((`RWPC_GLITCH_NS * `RWPC_CLK_MHZ + 999) / 1000)
`define RWPC_WAKE_CYC 2048
`define RWPC_CNT_W 16
`define RWPC_GCNT_W 4

`define RWPC_NUM_EINT 9
`define RWPC_NUM_GRP 4
`define RWPC_GRP_W 2
`define RWPC_EGRP_W 18
`define RWPC_NUM_PERIPH 16
`define RWPC_SYNC_W 11
`define RWPC_SY_RSTN 0
`define RWPC_SY_OSC 1
`define RWPC_SY_EINT 2
`define RWPC_AW 8

`define RWPC_OFS_CTRL 8'h00
`define RWPC_OFS_PCLKDIV 8'h04
`define RWPC_OFS_PPWR 8'h08
`define RWPC_OFS_EMODE 8'h0C
`define RWPC_OFS_EWAKE 8'h10
`define RWPC_OFS_EFLAG 8'h14
`define RWPC_OFS_EGRP 8'h18
`define RWPC_OFS_PLL 8'h1C
`define RWPC_OFS_STATUS 8'h20

`define RWPC_CTRL_IDLE 0
`define RWPC_CTRL_PDOWN 1
`define RWPC_CTRL_MAPRAM 2
`define RWPC_PLL_EN 0
`define RWPC_PLL_CON 1
`define RWPC_ST_SRCPIN 0
`define RWPC_ST_SRCWDT 1
`define RWPC_ST_OSCOK 2
`define RWPC_ST_PLLRUN 3

`define RWPC_DIV_QUARTER 2'h0
`define RWPC_DIV_FULL 2'h1
`define RWPC_DIV_HALF 2'h2
`define RWPC_LIM_FULL 2'h0
`define RWPC_LIM_HALF 2'h1
`define RWPC_LIM_QUARTER 2'h3
`define RWPC_PPWR_RST 16'hFFFF
`define RWPC_RESET_VECTOR 32'h0000_0000

`endif

// *** rwpc_pkg.sv ***
// Types of the reset, wake and power block
`include "rwpc_map.svh"
package rwpc_pkg;
	typedef enum logic [2:0] {S_HOLD, S_WAIT_OSC, S_COUNT, S_FLASH, S_RUN, S_IDLE, S_PDOWN}
		rwpc_fsm_t;

	typedef struct packed {
		logic hsel;
		logic hready;
		logic [1:0] htrans;
		logic [31:0] haddr;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} rwpc_ahb_req_t;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} rwpc_ahb_rsp_t;

	typedef struct packed {
		logic [`RWPC_SYNC_W-1:0] s1;
		logic [`RWPC_SYNC_W-1:0] s2;
		logic [`RWPC_SYNC_W-1:0] s3;
		logic [`RWPC_SYNC_W-1:0] stab;
		logic [`RWPC_GCNT_W-1:0] gcnt;
		logic pin_rst;
		rwpc_fsm_t fsm;
		logic from_reset;
		logic [`RWPC_CNT_W-1:0] wcnt;
		logic chip_rst;
		logic cpu_start;
		logic [31:0] fetch_addr;
		logic map_ram;
		logic [1:0] pclk_sel;
		logic [1:0] div_cnt;
		logic pclk_en;
		logic [`RWPC_NUM_PERIPH-1:0] ppwr;
		logic [`RWPC_NUM_EINT-1:0] emode;
		logic [`RWPC_NUM_EINT-1:0] ewake;
		logic [`RWPC_NUM_EINT-1:0] eflag;
		logic [`RWPC_EGRP_W-1:0] egrp;
		logic [`RWPC_NUM_GRP-1:0] irq;
		logic pll_en;
		logic pll_con;
		logic src_pin;
		logic src_wdt;
		logic wr_pend;
		logic rd_wait;
		logic [`RWPC_AW-1:0] dp_addr;
		logic [31:0] rdata;
	} rwpc_state_t;
endpackage : rwpc_pkg

// *** rwpc_top.sv ***
// Reset sequencing, wake-up timer, power modes, external interrupts and clock divider
`timescale 1ns/1ps

// Behaviour
// - Chip reset comes only from the reset pin or the watchdog request.
// - The reset pin is glitch filtered; short low pulses cause no reset.
// - Reset starts wake timer; held until pin released, oscillator, count, flash ready.
// - On reset release the processor starts fetching at address zero.
// - While chip reset holds, all control registers take their reset values.
// - Every power-down exit runs the wake-up timer before execution resumes.
// - The wake-up timer waits for a valid oscillator before counting.
// - Nine external interrupt inputs, edge or level, merged into four interrupts.
// - Each external interrupt input may wake from power-down when enabled.
// - A control bit maps the vectors at address zero to flash or RAM.
// - Idle halts execution until reset or interrupt; peripherals keep running.
// - Idle stops clocks of processor and memories.
// - Power-down stops the oscillator and gates all internal clocks.
// - Power-down keeps all state and holds output pin levels.
// - Power-down exits only on reset or a clockless external interrupt level.
// - Each peripheral has its own power control bit.
// - Peripheral clock runs at full, half or quarter processor clock rate.
// - After reset the peripheral clock runs at one quarter rate.
// - A running PLL stays active through idle mode.
// - After reset the PLL is off and bypassed.
module rwpc_top #(
	parameter int unsigned WAKE_CYCLES = `RWPC_WAKE_CYC,
	parameter int unsigned GLITCH_CYCLES = `RWPC_GLITCH_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input rwpc_pkg::rwpc_ahb_req_t ahb_req,
	output rwpc_pkg::rwpc_ahb_rsp_t ahb_rsp,
	// Reset sources
	input wire logic reset_pin_n,
	input wire logic wdt_reset_req,
	// Oscillator and flash controller
	input wire logic osc_valid,
	input wire logic flash_init_done,
	output logic osc_enable,
	// Interrupts
	input wire logic [`RWPC_NUM_EINT-1:0] eint_pin,
	input wire logic cpu_irq,
	output logic [`RWPC_NUM_GRP-1:0] eint_irq,
	// Processor control
	output logic chip_reset,
	output logic cpu_start,
	output logic [31:0] fetch_addr,
	output logic cpu_clock_en,
	output logic mem_clock_en,
	output logic vec_map_ram,
	// Peripheral clocks and pins
	output logic pclk_en,
	output logic [`RWPC_NUM_PERIPH-1:0] periph_clock_en,
	output logic pin_hold,
	output logic pll_enable,
	output logic pll_connect
);
	rwpc_pkg::rwpc_state_t st_q;
	rwpc_pkg::rwpc_state_t st_d;
	logic [`RWPC_SYNC_W-1:0] agree;
	logic [`RWPC_NUM_EINT-1:0] lvl;
	logic [`RWPC_NUM_EINT-1:0] rise;
	logic [`RWPC_NUM_EINT-1:0] active;
	logic [`RWPC_NUM_EINT-1:0] eclr;
	logic [1:0] sclr;
	logic [31:0] wdata;
	logic take;
	logic osc_ok;
	logic rst_evt;
	logic idle_wake;
	logic pd_wake;
	logic go_idle;
	logic go_pdown;

	// Members of one interrupt group
	function automatic logic [`RWPC_NUM_EINT-1:0] grp_members(
		input logic [`RWPC_EGRP_W-1:0] map,
		input int unsigned g
	);
		logic [`RWPC_NUM_EINT-1:0] m;
		m = '0;
		for (int i = 0; i < `RWPC_NUM_EINT; i++)
		begin
			m[i] = (map[i*`RWPC_GRP_W +: `RWPC_GRP_W] == `RWPC_GRP_W'(g));
		end
		return m;
	endfunction : grp_members

	// Divider terminal count for a rate code
	function automatic logic [1:0] div_limit(input logic [1:0] sel);
		logic [1:0] lim;
		lim = `RWPC_LIM_QUARTER;
		if (sel == `RWPC_DIV_FULL)
		begin
			lim = `RWPC_LIM_FULL;
		end
		else if (sel == `RWPC_DIV_HALF)
		begin
			lim = `RWPC_LIM_HALF;
		end
		return lim;
	endfunction : div_limit

	always_comb
	begin
		st_d = st_q;
		wdata = ahb_req.hwdata;
		eclr = '0;
		sclr = '0;
		go_idle = 1'b0;
		go_pdown = 1'b0;

		// Input synchronisers; a change counts once stages two and three agree
		st_d.s1 = {eint_pin, osc_valid, reset_pin_n};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		agree = ~(st_q.s2 ^ st_q.s3);
		st_d.stab = (st_q.s2 & agree) | (st_q.stab & ~agree);
		osc_ok = st_q.stab[`RWPC_SY_OSC];
		lvl = st_q.stab[`RWPC_SY_EINT +: `RWPC_NUM_EINT];
		rise = st_q.s2[`RWPC_SY_EINT +: `RWPC_NUM_EINT] & agree[`RWPC_SY_EINT +: `RWPC_NUM_EINT]
			& ~lvl;

		// Reset pin must stay low for the filter time
		if (!st_q.stab[`RWPC_SY_RSTN])
		begin
			if (st_q.gcnt != `RWPC_GCNT_W'(GLITCH_CYCLES - 1))
			begin
				st_d.gcnt = st_q.gcnt + `RWPC_GCNT_W'(1);
			end
			else
			begin
				st_d.pin_rst = 1'b1;
			end
		end
		else
		begin
			st_d.gcnt = '0;
			st_d.pin_rst = 1'b0;
		end
		rst_evt = st_q.pin_rst | wdt_reset_req;

		// Bus slave: writes complete in one data cycle, reads take one wait cycle
		take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
		st_d.wr_pend = take & ahb_req.hwrite;
		st_d.rd_wait = take & ~ahb_req.hwrite;
		if (take)
		begin
			st_d.dp_addr = ahb_req.haddr[`RWPC_AW-1:0];
		end
		if (st_q.wr_pend)
		begin
			unique case (st_q.dp_addr)
				`RWPC_OFS_CTRL:
				begin
					go_idle = wdata[`RWPC_CTRL_IDLE];
					go_pdown = wdata[`RWPC_CTRL_PDOWN];
					st_d.map_ram = wdata[`RWPC_CTRL_MAPRAM];
				end
				`RWPC_OFS_PCLKDIV: st_d.pclk_sel = wdata[1:0];
				`RWPC_OFS_PPWR: st_d.ppwr = wdata[`RWPC_NUM_PERIPH-1:0];
				`RWPC_OFS_EMODE: st_d.emode = wdata[`RWPC_NUM_EINT-1:0];
				`RWPC_OFS_EWAKE: st_d.ewake = wdata[`RWPC_NUM_EINT-1:0];
				`RWPC_OFS_EFLAG: eclr = wdata[`RWPC_NUM_EINT-1:0];
				`RWPC_OFS_EGRP: st_d.egrp = wdata[`RWPC_EGRP_W-1:0];
				`RWPC_OFS_PLL:
				begin
					st_d.pll_en = wdata[`RWPC_PLL_EN];
					st_d.pll_con = wdata[`RWPC_PLL_CON];
				end
				`RWPC_OFS_STATUS: sclr = wdata[`RWPC_ST_SRCWDT:`RWPC_ST_SRCPIN];
				default: ;
			endcase
		end
		if (st_q.rd_wait)
		begin
			st_d.rdata = '0;
			unique case (st_q.dp_addr)
				`RWPC_OFS_CTRL:
				begin
					st_d.rdata[`RWPC_CTRL_IDLE] = (st_q.fsm == rwpc_pkg::S_IDLE);
					st_d.rdata[`RWPC_CTRL_PDOWN] = (st_q.fsm == rwpc_pkg::S_PDOWN);
					st_d.rdata[`RWPC_CTRL_MAPRAM] = st_q.map_ram;
				end
				`RWPC_OFS_PCLKDIV: st_d.rdata[1:0] = st_q.pclk_sel;
				`RWPC_OFS_PPWR: st_d.rdata[`RWPC_NUM_PERIPH-1:0] = st_q.ppwr;
				`RWPC_OFS_EMODE: st_d.rdata[`RWPC_NUM_EINT-1:0] = st_q.emode;
				`RWPC_OFS_EWAKE: st_d.rdata[`RWPC_NUM_EINT-1:0] = st_q.ewake;
				`RWPC_OFS_EFLAG: st_d.rdata[`RWPC_NUM_EINT-1:0] = st_q.eflag;
				`RWPC_OFS_EGRP: st_d.rdata[`RWPC_EGRP_W-1:0] = st_q.egrp;
				`RWPC_OFS_PLL:
				begin
					st_d.rdata[`RWPC_PLL_EN] = st_q.pll_en;
					st_d.rdata[`RWPC_PLL_CON] = st_q.pll_con;
				end
				`RWPC_OFS_STATUS:
				begin
					st_d.rdata[`RWPC_ST_SRCPIN] = st_q.src_pin;
					st_d.rdata[`RWPC_ST_SRCWDT] = st_q.src_wdt;
					st_d.rdata[`RWPC_ST_OSCOK] = osc_ok;
					st_d.rdata[`RWPC_ST_PLLRUN] = pll_enable;
				end
				default: ;
			endcase
		end

		// External interrupts: sticky edge flags, set beats clear
		st_d.eflag = (st_q.eflag & ~eclr) | rise;
		active = (st_q.emode & st_q.eflag) | (~st_q.emode & lvl);
		for (int g = 0; g < `RWPC_NUM_GRP; g++)
		begin
			st_d.irq[g] = |(active & grp_members(st_q.egrp, g));
		end
		idle_wake = cpu_irq | (|st_q.irq);
		pd_wake = |(lvl & st_q.ewake);

		// Peripheral clock divider, stopped in power-down
		st_d.pclk_en = 1'b0;
		if (st_q.fsm != rwpc_pkg::S_PDOWN && !st_q.chip_rst)
		begin
			if (st_q.div_cnt >= div_limit(st_q.pclk_sel))
			begin
				st_d.div_cnt = '0;
				st_d.pclk_en = 1'b1;
			end
			else
			begin
				st_d.div_cnt = st_q.div_cnt + 2'h1;
			end
		end

		// Sequencer
		st_d.cpu_start = 1'b0;
		unique case (st_q.fsm)
			rwpc_pkg::S_HOLD:
			begin
				if (!st_q.pin_rst)
				begin
					st_d.fsm = rwpc_pkg::S_WAIT_OSC;
				end
			end
			rwpc_pkg::S_WAIT_OSC:
			begin
				st_d.wcnt = '0;
				if (osc_ok)
				begin
					st_d.fsm = rwpc_pkg::S_COUNT;
				end
			end
			rwpc_pkg::S_COUNT:
			begin
				if (!osc_ok)
				begin
					st_d.fsm = rwpc_pkg::S_WAIT_OSC;
				end
				else if (st_q.wcnt == `RWPC_CNT_W'(WAKE_CYCLES - 1))
				begin
					st_d.fsm = st_q.from_reset ? rwpc_pkg::S_FLASH : rwpc_pkg::S_RUN;
				end
				else
				begin
					st_d.wcnt = st_q.wcnt + `RWPC_CNT_W'(1);
				end
			end
			rwpc_pkg::S_FLASH:
			begin
				if (flash_init_done)
				begin
					st_d.fsm = rwpc_pkg::S_RUN;
					st_d.chip_rst = 1'b0;
					st_d.from_reset = 1'b0;
					st_d.cpu_start = 1'b1;
					st_d.fetch_addr = `RWPC_RESET_VECTOR;
				end
			end
			rwpc_pkg::S_RUN:
			begin
				if (go_pdown)
				begin
					st_d.fsm = rwpc_pkg::S_PDOWN;
				end
				else if (go_idle)
				begin
					st_d.fsm = rwpc_pkg::S_IDLE;
				end
			end
			rwpc_pkg::S_IDLE:
			begin
				if (idle_wake)
				begin
					st_d.fsm = rwpc_pkg::S_RUN;
				end
			end
			rwpc_pkg::S_PDOWN:
			begin
				if (pd_wake)
				begin
					st_d.fsm = rwpc_pkg::S_WAIT_OSC;
				end
			end
		endcase

		// Chip reset entry from any state; source flags survive it
		st_d.src_pin = (st_q.src_pin & ~sclr[0]) | st_q.pin_rst;
		st_d.src_wdt = (st_q.src_wdt & ~sclr[1]) | wdt_reset_req;
		if (rst_evt)
		begin
			st_d.fsm = rwpc_pkg::S_HOLD;
			st_d.chip_rst = 1'b1;
			st_d.from_reset = 1'b1;
			st_d.wcnt = '0;
		end
		if (st_q.chip_rst)
		begin
			st_d.map_ram = 1'b0;
			st_d.pclk_sel = `RWPC_DIV_QUARTER;
			st_d.div_cnt = '0;
			st_d.ppwr = `RWPC_PPWR_RST;
			st_d.emode = '0;
			st_d.ewake = '0;
			st_d.eflag = '0;
			st_d.egrp = '0;
			st_d.irq = '0;
			st_d.pll_en = 1'b0;
			st_d.pll_con = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.stab <= '1;
			st_q.s1 <= '1;
			st_q.s2 <= '1;
			st_q.s3 <= '1;
			st_q.fsm <= rwpc_pkg::S_HOLD;
			st_q.chip_rst <= 1'b1;
			st_q.from_reset <= 1'b1;
			st_q.fetch_addr <= `RWPC_RESET_VECTOR;
			st_q.pclk_sel <= `RWPC_DIV_QUARTER;
			st_q.ppwr <= `RWPC_PPWR_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign ahb_rsp.hreadyout = ~st_q.rd_wait;
	assign ahb_rsp.hresp = 1'b0;
	assign ahb_rsp.hrdata = st_q.rdata;
	assign chip_reset = st_q.chip_rst;
	assign cpu_start = st_q.cpu_start;
	assign fetch_addr = st_q.fetch_addr;
	assign cpu_clock_en = (st_q.fsm == rwpc_pkg::S_RUN);
	assign mem_clock_en = (st_q.fsm == rwpc_pkg::S_RUN);
	assign osc_enable = (st_q.fsm != rwpc_pkg::S_PDOWN);
	assign pin_hold = (st_q.fsm == rwpc_pkg::S_PDOWN);
	assign periph_clock_en = pin_hold ? '0 : st_q.ppwr;
	assign pclk_en = st_q.pclk_en;
	assign eint_irq = st_q.irq;
	assign vec_map_ram = st_q.map_ram;
	assign pll_enable = st_q.pll_en & ~pin_hold;
	assign pll_connect = st_q.pll_con & pll_enable;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_pd_exit;
		st_q.fsm == rwpc_pkg::S_PDOWN ##1 st_q.fsm != rwpc_pkg::S_PDOWN;
	endsequence
	sequence s_count_done;
		st_q.fsm == rwpc_pkg::S_COUNT ##1 st_q.fsm inside {rwpc_pkg::S_FLASH, rwpc_pkg::S_RUN};
	endsequence

	chk_reset_source: assert property ($rose(chip_reset) |-> $past(st_q.pin_rst | wdt_reset_req))
		else $error("chip reset without a source");
	chk_glitch_filter: assert property ($rose(st_q.pin_rst) |-> $past(st_q.gcnt) == `RWPC_GCNT_W'(GLITCH_CYCLES - 1))
		else $error("pin reset before filter time");
	chk_release_cond: assert property ($fell(chip_reset) |-> $past(flash_init_done) && osc_ok && !st_q.pin_rst)
		else $error("reset released too early");
	chk_boot_vector: assert property ($fell(chip_reset) |-> cpu_start && fetch_addr == `RWPC_RESET_VECTOR && cpu_clock_en)
		else $error("bad start after reset");
	chk_pd_timer: assert property (s_pd_exit |-> st_q.fsm inside {rwpc_pkg::S_WAIT_OSC, rwpc_pkg::S_HOLD})
		else $error("power-down exit skipped the wake timer");
	chk_count_osc: assert property (st_q.fsm == rwpc_pkg::S_COUNT && st_q.wcnt != '0 |-> $past(osc_ok))
		else $error("wake count without oscillator");
	chk_wake_count: assert property (s_count_done |-> $past(st_q.wcnt) == `RWPC_CNT_W'(WAKE_CYCLES - 1))
		else $error("wake count length wrong");
	chk_pd_enable: assert property (s_pd_exit ##0 st_q.fsm == rwpc_pkg::S_WAIT_OSC |-> $past(|(lvl & st_q.ewake)))
		else $error("power-down exit without enabled wake input");
	chk_idle_clocks: assert property (st_q.fsm == rwpc_pkg::S_IDLE |-> !cpu_clock_en && !mem_clock_en && osc_enable)
		else $error("idle clock gating wrong");
	chk_pdown_clocks: assert property (pin_hold |-> !osc_enable && periph_clock_en == '0 && !pll_enable ##1 !pclk_en)
		else $error("power-down clocks still running");
	chk_idle_exit: assert property (st_q.fsm == rwpc_pkg::S_IDLE && idle_wake && !rst_evt |=> cpu_clock_en)
		else $error("idle exit not on next edge");
	chk_pclk_quarter: assert property ($fell(rst) |-> st_q.pclk_sel == `RWPC_DIV_QUARTER && !st_q.pll_en)
		else $error("reset divider or pll state wrong");
	chk_pclk_half: assert property (pclk_en && st_q.pclk_sel == `RWPC_DIV_HALF && !rst_evt && !st_q.wr_pend && !go_pdown |=> !pclk_en)
		else $error("half rate pulse spacing wrong");
endmodule : rwpc_top

// *** rwpc_far_model.sv ***
// Oscillator and flash controller model facing the reset, wake and power block
`timescale 1ns/1ps
module rwpc_far_model #(
	parameter int OSC_DLY = 5,
	parameter int FLASH_DLY = 3
)(
	// Clock
	input wire logic clk,
	// Controls from the block; slow comes from the bench
	input wire logic osc_enable,
	input wire logic chip_reset,
	input wire logic slow,
	// Status to the block
	output logic osc_valid,
	output logic flash_init_done
);
	int osc_cnt = 0;
	int fl_cnt = 0;
	always @(posedge clk)
	begin
		osc_cnt <= osc_enable ? osc_cnt + 1 : 0;
		fl_cnt <= (chip_reset && osc_valid) ? fl_cnt + 1 : 0;
	end
	// Oscillator output valid only after start-up, lost at once when stopped
	assign osc_valid = osc_enable && (osc_cnt >= OSC_DLY);
	// Flash init completes some cycles into each chip reset, much later when slow
	assign flash_init_done = fl_cnt >= (slow ? 16 * FLASH_DLY : FLASH_DLY);
endmodule : rwpc_far_model

// *** tb.sv ***
// Self-checking bench for the reset, wake and power block
`timescale 1ns/1ps
`include "rwpc_map.svh"
module tb;
	localparam int WAKE = 8;
	localparam int LIM = 400;
	logic clk;
	logic rst;
	rwpc_pkg::rwpc_ahb_req_t req;
	rwpc_pkg::rwpc_ahb_req_t req_w;
	rwpc_pkg::rwpc_ahb_rsp_t rsp;
	logic reset_pin_n;
	logic wdt_reset_req;
	logic osc_valid;
	logic flash_init_done;
	logic osc_enable;
	logic [`RWPC_NUM_EINT-1:0] eint_pin;
	logic cpu_irq;
	logic [`RWPC_NUM_GRP-1:0] eint_irq;
	logic chip_reset;
	logic cpu_start;
	logic [31:0] fetch_addr;
	logic cpu_clock_en;
	logic mem_clock_en;
	logic vec_map_ram;
	logic pclk_en;
	logic [`RWPC_NUM_PERIPH-1:0] periph_clock_en;
	logic pin_hold;
	logic pll_enable;
	logic pll_connect;
	logic slow;
	int miscompares = 0;
	int compares = 0;
	int seed = 63;
	int shadow [64];
	int n;
	int k;
	int j;
	logic [31:0] rd;
	logic [31:0] v;
	logic [1:0] st;

	rwpc_top #(.WAKE_CYCLES(WAKE), .GLITCH_CYCLES(4)) i_rwpc_top (
		.clk(clk), .rst(rst), .ahb_req(req_w), .ahb_rsp(rsp),
		.reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req),
		.osc_valid(osc_valid), .flash_init_done(flash_init_done), .osc_enable(osc_enable),
		.eint_pin(eint_pin), .cpu_irq(cpu_irq), .eint_irq(eint_irq),
		.chip_reset(chip_reset), .cpu_start(cpu_start), .fetch_addr(fetch_addr),
		.cpu_clock_en(cpu_clock_en), .mem_clock_en(mem_clock_en), .vec_map_ram(vec_map_ram),
		.pclk_en(pclk_en), .periph_clock_en(periph_clock_en), .pin_hold(pin_hold),
		.pll_enable(pll_enable), .pll_connect(pll_connect)
	);
	rwpc_far_model i_rwpc_far_model (
		.clk(clk), .osc_enable(osc_enable), .chip_reset(chip_reset), .slow(slow),
		.osc_valid(osc_valid), .flash_init_done(flash_init_done)
	);

	// The one slave's hreadyout is the bus hready
	always_comb
	begin
		req_w = req;
		req_w.hready = rsp.hreadyout;
	end

	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// Hold the phase until hready is seen high at a rising edge
	task automatic ready(output logic [31:0] d);
		logic ok;
		do
		begin
			@(negedge clk);
			ok = rsp.hreadyout;
			d = rsp.hrdata;
			@(posedge clk);
		end
		while (ok !== 1'h1);
	endtask : ready

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		req.hsel <= 1'h1;
		req.htrans <= 2'h2;
		req.haddr <= {24'h0, a};
		req.hwrite <= wr;
		req.hsize <= 3'h2;
		ready(rd);
		req.htrans <= 2'h0;
		req.hwdata <= wd;
		ready(rd);
	endtask : bus

	function automatic logic [31:0] msk(input logic [7:0] a);
		case (a)
			`RWPC_OFS_CTRL: return 32'h4;
			`RWPC_OFS_PCLKDIV, `RWPC_OFS_PLL: return 32'h3;
			`RWPC_OFS_PPWR: return 32'hFFFF;
			`RWPC_OFS_EMODE, `RWPC_OFS_EWAKE: return 32'h1FF;
			`RWPC_OFS_EGRP: return 32'h3FFFF;
			default: return 32'h0;
		endcase
	endfunction : msk

	task automatic shreset;
		foreach (shadow[i])
			shadow[i] = 0;
		shadow[`RWPC_OFS_PPWR >> 2] = `RWPC_PPWR_RST;
	endtask : shreset

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
		shadow[a[7:2]] = d & msk(a);
	endtask : wr

	task automatic rdchk(input logic [7:0] a);
		bus(1'h0, a, 32'h0);
		chk(rd, shadow[a[7:2]]);
	endtask : rdchk

	// Bounded wait: 0 chip reset, 1 processor clock, 2 any group interrupt
	task automatic wait_on(input int sel, input logic val);
		logic s;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			s = (sel == 0) ? chip_reset : (sel == 1) ? cpu_clock_en : |eint_irq;
		end
		while (s !== val && n < LIM);
		if (n >= LIM)
		begin
			miscompares++;
			$display("[FAIL] %0t wait expired", $time);
		end
	endtask : wait_on

	task automatic pcount(output int p);
		p = 0;
		repeat (4) @(negedge clk);
		repeat (16)
		begin
			@(negedge clk);
			p += (pclk_en === 1'h1);
		end
	endtask : pcount

	initial
	begin
		#2000000;
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	initial
	begin
		req = '0;
		rst = 1'h1;
		reset_pin_n = 1'h1;
		wdt_reset_req = 1'h0;
		eint_pin = '0;
		cpu_irq = 1'h0;
		slow = 1'h0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		shreset();
		@(negedge clk);
		chk({chip_reset, cpu_clock_en, pll_enable, pll_connect}, 4'h8);
		chk(periph_clock_en, 16'hFFFF);
		bus(1'h1, `RWPC_OFS_PPWR, 32'h0);
		wait_on(0, 1'h0);
		chk(n > WAKE, 1'h1);
		st[0] = cpu_start;
		chk(fetch_addr, `RWPC_RESET_VECTOR);
		@(negedge clk);
		st[1] = cpu_start;
		chk(st[0] ^ st[1], 1'h1);
		chk(cpu_clock_en, 1'h1);
		pcount(n);
		chk(n, 4);
		rdchk(`RWPC_OFS_PPWR);
		rdchk(`RWPC_OFS_PCLKDIV);
		rdchk(`RWPC_OFS_PLL);
		rdchk(8'h40);
		v = $random(seed);
		wr(`RWPC_OFS_PPWR, v);
		rdchk(`RWPC_OFS_PPWR);
		@(negedge clk);
		chk(periph_clock_en, v[15:0]);
		for (int s = 0; s < 4; s++)
		begin
			wr(`RWPC_OFS_PCLKDIV, s);
			pcount(n);
			chk(n, (s == 1) ? 16 : (s == 2) ? 8 : 4);
			rdchk(`RWPC_OFS_PCLKDIV);
		end
		wr(`RWPC_OFS_CTRL, 32'h4);
		@(negedge clk);
		chk(vec_map_ram, 1'h1);
		wr(`RWPC_OFS_CTRL, 32'h0);
		@(negedge clk);
		chk(vec_map_ram, 1'h0);
		wr(`RWPC_OFS_PLL, 32'h3);
		@(negedge clk);
		chk({pll_enable, pll_connect}, 2'h3);
		bus(1'h1, `RWPC_OFS_CTRL, 32'h1);
		@(negedge clk);
		chk({cpu_clock_en, mem_clock_en, osc_enable, pll_enable}, 4'h3);
		pcount(n);
		chk(n, 4);
		@(posedge clk);
		cpu_irq <= 1'h1;
		@(negedge clk);
		chk(cpu_clock_en, 1'h0);
		@(negedge clk);
		chk(cpu_clock_en, 1'h1);
		@(posedge clk);
		cpu_irq <= 1'h0;
		v = $random(seed);
		wr(`RWPC_OFS_EGRP, v);
		wr(`RWPC_OFS_EMODE, 32'h0);
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk);
			eint_pin <= 9'h1 << i;
			wait_on(2, 1'h1);
			chk(eint_irq, 4'h1 << v[2*i +: 2]);
			@(posedge clk);
			eint_pin <= '0;
			wait_on(2, 1'h0);
		end
		wr(`RWPC_OFS_EMODE, 32'h1);
		@(posedge clk);
		eint_pin <= 9'h1;
		repeat (2) @(posedge clk);
		eint_pin <= '0;
		wait_on(2, 1'h1);
		repeat (6) @(negedge clk);
		chk(|eint_irq, 1'h1);
		bus(1'h1, `RWPC_OFS_EFLAG, 32'h1);
		repeat (2) @(negedge clk);
		chk(|eint_irq, 1'h0);
		wr(`RWPC_OFS_EMODE, 32'h0);
		k = {$random(seed)} % 9;
		j = (k + 1) % 9;
		wr(`RWPC_OFS_EWAKE, 32'h1 << k);
		bus(1'h1, `RWPC_OFS_CTRL, 32'h2);
		@(negedge clk);
		chk({osc_enable, pin_hold, cpu_clock_en, pll_enable}, 4'h4);
		@(posedge clk);
		eint_pin <= 9'h1 << j;
		repeat (12) @(negedge clk);
		chk({cpu_clock_en, pin_hold}, 2'h1);
		@(posedge clk);
		eint_pin <= 9'h1 << k;
		wait_on(1, 1'h1);
		chk(n > WAKE + 5, 1'h1);
		@(posedge clk);
		eint_pin <= '0;
		rdchk(`RWPC_OFS_PPWR);
		rdchk(`RWPC_OFS_EGRP);
		@(posedge clk);
		reset_pin_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_pin_n <= 1'h1;
		repeat (15) @(negedge clk);
		chk(chip_reset, 1'h0);
		@(posedge clk);
		reset_pin_n <= 1'h0;
		slow <= 1'h1;
		repeat (20) @(posedge clk);
		reset_pin_n <= 1'h1;
		wait_on(0, 1'h0);
		chk(n > 24, 1'h1);
		shreset();
		rdchk(`RWPC_OFS_PPWR);
		rdchk(`RWPC_OFS_PCLKDIV);
		rdchk(`RWPC_OFS_PLL);
		bus(1'h0, `RWPC_OFS_STATUS, 32'h0);
		chk(rd[1:0], 2'h1);
		wr(`RWPC_OFS_CTRL, 32'h4);
		@(posedge clk);
		wdt_reset_req <= 1'h1;
		slow <= 1'h0;
		@(posedge clk);
		wdt_reset_req <= 1'h0;
		wait_on(0, 1'h1);
		wait_on(0, 1'h0);
		chk(vec_map_ram, 1'h0);
		bus(1'h0, `RWPC_OFS_STATUS, 32'h0);
		chk(rd[1:0], 2'h3);
		final_report();
	end
endmodule : tb
